// ---- rtl/inc_skip_pkg.sv ----
package inc_skip_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam logic [DATA_W-1:0] INC_STEP = 8'h01;
  localparam logic [DATA_W-1:0] ZERO_VAL = 8'h00;
  localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST = 8'h00;
  // Opcode selection presented by the decoder
  localparam logic [1:0] OP_NONE = 2'h0;
  localparam logic [1:0] OP_INC_MEM = 2'h1;
  localparam logic [1:0] OP_INC_ACC = 2'h2;
  // Cycle counts of a skipping and non skipping instruction
  localparam int SKIP_CYCLES = 3;
  localparam int PLAIN_CYCLES = 2;
endpackage

// ---- rtl/inc_unit.sv ----
`timescale 1ns/1ps
module inc_unit
  import inc_skip_pkg::*;
(
  input wire logic [DATA_W-1:0] operand_in,
  output logic [DATA_W-1:0] sum_out,
  output logic zero_out
);
  always_comb begin
    sum_out = operand_in + INC_STEP;
    zero_out = (sum_out == ZERO_VAL);
  end
endmodule // inc_unit

// ---- rtl/increment_skip_if_zero_exec.sv ----
`timescale 1ns/1ps
// Function
// - Memory form reads operand byte, adds one, writes sum back to same address.
// - Zero result skips the instruction right after the increment.
// - A skip inserts a dummy cycle, making the instruction three cycles.
// - Nonzero result does not skip; execution continues sequentially.
// - Accumulator form loads operand plus one into accumulator, memory untouched.
// - Accumulator form skips when the new accumulator value is zero.
module increment_skip_if_zero_exec
  import inc_skip_pkg::*;
(
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic start_in,
  input wire logic [1:0] op_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] mem_rdata_in,
  output logic busy_out,
  output logic done_out,
  output logic mem_re_out,
  output logic mem_we_out,
  output logic [ADDR_W-1:0] mem_addr_out,
  output logic [DATA_W-1:0] mem_wdata_out,
  output logic acc_we_out,
  output logic [DATA_W-1:0] acc_out,
  output logic skip_out,
  output logic dummy_out
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_EXEC = 2'b11,
    ST_DUMMY = 2'b10
  } state_e;

  typedef struct packed {
    state_e st;
    logic to_acc;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] acc;
    logic we;
    logic acc_we;
    logic skip;
    logic dummy;
    logic done;
  } state_s;

  state_s q_r;
  state_s q_nxt;
  logic [DATA_W-1:0] sum;
  logic sum_zero;

  inc_unit u_inc (
    .operand_in(mem_rdata_in),
    .sum_out(sum),
    .zero_out(sum_zero)
  );

  function automatic logic is_inc_op(input logic [1:0] op);
    is_inc_op = (op == OP_INC_MEM) || (op == OP_INC_ACC);
  endfunction

  always_comb begin
    q_nxt = q_r;
    q_nxt.we = 1'b0;
    q_nxt.acc_we = 1'b0;
    q_nxt.skip = 1'b0;
    q_nxt.done = 1'b0;
    q_nxt.dummy = 1'b0;
    case (q_r.st)
      ST_IDLE: begin
        if (start_in && is_inc_op(op_in)) begin
          q_nxt.st = ST_READ;
          q_nxt.addr = addr_in;
          q_nxt.to_acc = (op_in == OP_INC_ACC);
        end
      end
      ST_READ: begin
        // Data memory answers the read address in this cycle
        if (q_r.to_acc) begin
          q_nxt.acc = sum;
          q_nxt.acc_we = 1'b1;
        end else begin
          q_nxt.wdata = sum;
          q_nxt.we = 1'b1;
        end
        q_nxt.skip = sum_zero;
        q_nxt.st = ST_EXEC;
      end
      ST_EXEC: begin
        if (q_r.skip) begin
          q_nxt.st = ST_DUMMY;
          q_nxt.dummy = 1'b1;
        end else begin
          q_nxt.st = ST_IDLE;
          q_nxt.done = 1'b1;
        end
      end
      ST_DUMMY: begin
        q_nxt.st = ST_IDLE;
        q_nxt.done = 1'b1;
      end
      default: begin
        q_nxt.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      q_r <= '{
        st: ST_IDLE,
        to_acc: 1'b0,
        addr: ADDR_RST,
        wdata: ZERO_VAL,
        acc: ACC_RST,
        we: 1'b0,
        acc_we: 1'b0,
        skip: 1'b0,
        dummy: 1'b0,
        done: 1'b0
      };
    end else begin
      q_r <= q_nxt;
    end
  end

  assign busy_out = (q_r.st != ST_IDLE);
  assign done_out = q_r.done;
  assign mem_re_out = (q_r.st == ST_READ);
  assign mem_we_out = q_r.we;
  assign mem_addr_out = q_r.addr;
  assign mem_wdata_out = q_r.wdata;
  assign acc_we_out = q_r.acc_we;
  assign acc_out = q_r.acc;
  assign skip_out = q_r.skip;
  assign dummy_out = q_r.dummy;

  // Cycle counter from start acceptance, checked against the documented counts
  logic [2:0] cyc_r;
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cyc_r <= 3'h0;
    end else if (q_r.st == ST_IDLE) begin
      cyc_r <= 3'h0;
    end else begin
      cyc_r <= cyc_r + 3'h1;
    end
  end

  a_mem_writeback: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (q_r.st == ST_READ && !q_r.to_acc) |=> (mem_we_out && mem_wdata_out == $past(mem_rdata_in) + INC_STEP
    && mem_addr_out == $past(q_r.addr))) else $error("memory form did not write back sum");
  a_zero_skip: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (q_r.st == ST_READ && (&mem_rdata_in)) |=> skip_out ##1 dummy_out)
    else $error("zero result did not skip");
  a_skip_three: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (dummy_out && done_out == 1'b0) |=> (done_out && cyc_r == 3'(SKIP_CYCLES)))
    else $error("skipping instruction not three cycles");
  a_no_skip: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (q_r.st == ST_READ && !(&mem_rdata_in)) |=> !skip_out ##1 (done_out && !dummy_out))
    else $error("nonzero result skipped");
  a_acc_only: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (q_r.st == ST_READ && q_r.to_acc) |=> (acc_we_out && !mem_we_out && acc_out == $past(sum)))
    else $error("accumulator form wrong");
  a_acc_zero: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    acc_we_out |-> (skip_out == (acc_out == ZERO_VAL))) else $error("accumulator skip mismatch");
  a_wrap_zero: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (&mem_rdata_in) |-> (sum == ZERO_VAL)) else $error("increment did not wrap");
  a_plain_two: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (done_out && !$past(dummy_out)) |-> (cyc_r == 3'(PLAIN_CYCLES)))
    else $error("plain instruction not two cycles");

  // Pulses to the rest of the core must never merge into longer levels
  a_done_pulse: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    done_out |=> !done_out) else $error("done held longer than one cycle");
  a_read_once: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    mem_re_out |=> !mem_re_out) else $error("read strobe held too long");
  a_one_target: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    !(mem_we_out && acc_we_out)) else $error("both memory and accumulator written");

  // Held results only move on their own write strobe
  a_acc_kept: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    !acc_we_out |-> $stable(acc_out)) else $error("accumulator changed without write");
  a_wdata_kept: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    !mem_we_out |-> $stable(mem_wdata_out)) else $error("write data changed without write");
  a_addr_kept: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    busy_out |=> $stable(mem_addr_out)) else $error("address changed while busy");

  // Skip handshake towards fetch: dummy always follows a skip
  a_dummy_after: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    dummy_out |-> $past(skip_out)) else $error("dummy cycle without skip");
  a_skip_exec: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    skip_out |-> (q_r.st == ST_EXEC)) else $error("skip outside execute cycle");
  a_done_idle: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    done_out |-> !busy_out) else $error("done while still busy");

  // Codes outside the two increment forms are dropped without a trace
  a_refuse_code: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (!busy_out && start_in && !is_inc_op(op_in)) |=> !busy_out)
    else $error("unknown opcode started work");
endmodule // increment_skip_if_zero_exec

// ---- bench/increment_skip_if_zero_exec_tb.sv ----
`timescale 1ns/1ps
module increment_skip_if_zero_exec_tb;
  import inc_skip_pkg::*;
  logic clk_in = 0;
  logic arst_n_in = 0;
  logic start_in = 0;
  logic [1:0] op_in = OP_NONE;
  logic [ADDR_W-1:0] addr_in = ADDR_RST;
  logic [DATA_W-1:0] mem_rdata_in = ZERO_VAL;
  logic busy_out, done_out, mem_re_out, mem_we_out, acc_we_out, skip_out, dummy_out;
  logic [ADDR_W-1:0] mem_addr_out;
  logic [DATA_W-1:0] mem_wdata_out, acc_out;
  int error_cnt = 0;
  int compares = 0;
  always #10 clk_in = ~clk_in;
  increment_skip_if_zero_exec uut (.clk_in(clk_in), .arst_n_in(arst_n_in), .start_in(start_in), .op_in(op_in),
    .addr_in(addr_in), .mem_rdata_in(mem_rdata_in), .busy_out(busy_out), .done_out(done_out),
    .mem_re_out(mem_re_out), .mem_we_out(mem_we_out), .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out),
    .acc_we_out(acc_we_out), .acc_out(acc_out), .skip_out(skip_out), .dummy_out(dummy_out));
  task close_out;
    $display("mismatches %0d of %0d compares", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Runs one instruction, counting pulses until done; memory data held for the whole run
  task automatic exec(input logic [1:0] op, input logic [7:0] a, input logic [7:0] d);
    logic [7:0] s;
    logic z;
    int n, we, ae, sk, dm;
    s = d + INC_STEP;
    z = (s == ZERO_VAL);
    n = 0; we = 0; ae = 0; sk = 0; dm = 0;
    start_in = 1; op_in = op; addr_in = a; mem_rdata_in = d;
    @(posedge clk_in); #2;
    start_in = 0;
    chk("mem_re", 8'h01, {7'h00, mem_re_out});
    do begin
      @(posedge clk_in); #2;
      n++;
      we += (mem_we_out === 1'b1); ae += (acc_we_out === 1'b1);
      sk += (skip_out === 1'b1); dm += (dummy_out === 1'b1);
    end while (done_out !== 1'b1 && n < 8);
    if (done_out !== 1'b1) begin
      error_cnt++;
      $display("wrong value done expected 1 seen %b", done_out);
      close_out;
    end
    chk("cycles", z ? 8'(SKIP_CYCLES) : 8'(PLAIN_CYCLES), 8'(n));
    chk("skip", {7'h00, z}, 8'(sk));
    chk("dummy", {7'h00, z}, 8'(dm));
    if (op == OP_INC_MEM) begin
      chk("mem_we", 8'h01, 8'(we));
      chk("acc_we", 8'h00, 8'(ae));
      chk("mem_wdata", s, mem_wdata_out);
      chk("mem_addr", a, mem_addr_out);
    end else begin
      chk("acc_we", 8'h01, 8'(ae));
      chk("mem_we", 8'h00, 8'(we));
      chk("acc", s, acc_out);
    end
    @(posedge clk_in); #2;
  endtask
  task mem_plain;
    exec(OP_INC_MEM, 8'h12, 8'h34);
  endtask
  task mem_wrap;
    exec(OP_INC_MEM, 8'hA5, 8'hFF);
  endtask
  task acc_plain;
    exec(OP_INC_ACC, 8'h40, 8'h7F);
  endtask
  task acc_wrap;
    exec(OP_INC_ACC, 8'h3C, 8'hFF);
  endtask
  // Codes 0 and 3 must leave the block idle
  task refused;
    for (int i = 0; i < 4; i += 3) begin
      start_in = 1; op_in = 2'(i);
      @(posedge clk_in); #2;
      start_in = 0;
      repeat (3) begin
        chk("busy", 8'h00, {7'h00, busy_out});
        chk("mem_we", 8'h00, {7'h00, mem_we_out});
        @(posedge clk_in); #2;
      end
    end
  endtask
  // A second start while busy must not retarget or retrigger the instruction
  task automatic busy_ignored;
    int n, ae;
    n = 0; ae = 0;
    start_in = 1; op_in = OP_INC_MEM; addr_in = 8'h21; mem_rdata_in = 8'h05;
    @(posedge clk_in); #2;
    op_in = OP_INC_ACC; addr_in = 8'h99;
    do begin
      @(posedge clk_in); #2;
      n++;
      ae += (acc_we_out === 1'b1);
    end while (done_out !== 1'b1 && n < 8);
    start_in = 0;
    if (done_out !== 1'b1) begin
      error_cnt++;
      $display("wrong value done expected 1 seen %b", done_out);
      close_out;
    end
    chk("acc_we", 8'h00, 8'(ae));
    chk("mem_addr", 8'h21, mem_addr_out);
    chk("mem_wdata", 8'h06, mem_wdata_out);
    @(posedge clk_in); #2;
    chk("busy", 8'h00, {7'h00, busy_out});
  endtask
  initial begin
    repeat (6) @(posedge clk_in);
    #2;
    arst_n_in = 1;
    mem_plain;
    mem_wrap;
    acc_plain;
    acc_wrap;
    refused;
    busy_ignored;
    close_out;
  end
endmodule // increment_skip_if_zero_exec_tb
